// File: core/fmps_pkg.sv
// Purpose: Shared constants for the floppy mode strap and pin select block
// Assumes: One 40 MHz clock, synchronous active-high reset
// Notes:   Straps are pins and pass a two-stage synchroniser first
package fmps_pkg;

    typedef enum logic [1:0] {
        FMPS_MODE_FIRST,
        FMPS_MODE_SECOND,
        FMPS_MODE_THIRD,
        FMPS_MODE_ILLEGAL
    } fmps_mode_e;

    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned SYNC_STAGES   = 2;

    // Strap codes as {identity, encoding}
    localparam logic [1:0] STRAP_FIRST   = 2'h3;
    localparam logic [1:0] STRAP_ILLEGAL = 2'h2;
    localparam logic [1:0] STRAP_THIRD   = 2'h1;
    localparam logic [1:0] STRAP_SECOND  = 2'h0;

    // Data rate codes: 0 = 500 kbps, 1 = 300, 2 = 250, 3 = 1 Mbps
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_1M   = 2'h3;

    // Control register field positions
    localparam int unsigned DOUT_DMA_EN_BIT  = 3;
    localparam int unsigned PWR_IDLE_SEL_BIT = 4;
    localparam int unsigned FUNC_ENC_SEL_BIT = 7;

    // Last count of the post-reset settle counter
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    localparam logic [1:0] STRAP_RESET = 2'h0;

endpackage : fmps_pkg

// File: core/fmps_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to ref_clk_i
// Notes:   First stage is read only by the second stage
module fmps_sync
    import fmps_pkg::*;
#(
    parameter int unsigned WIDTH = 2
)
(
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             srst_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : fmps_sync

// File: core/fmps_top.sv
// Purpose: Strap-selected compatibility mode and shared pin functions
// Assumes: Straps stable around reset release; one clock domain
// Notes:   Straps are captured once after the synchroniser settles
module fmps_top
    import fmps_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    // Strap pins
    input  wire logic       ident_strap_i,
    input  wire logic       encoding_strap_i,
    // Controller state and control bits
    input  wire logic [7:0] digital_output_reg_i,
    input  wire logic [7:0] power_mgmt_control_reg_i,
    input  wire logic [7:0] function_control_reg_i,
    input  wire logic [1:0] data_rate_i,
    input  wire logic       fdc_idle_i,
    input  wire logic       fdc_power_down_i,
    input  wire logic       encoding_format_i,
    input  wire logic       epp_wait_i,
    input  wire logic       drive1_motor_select_i,
    input  wire logic       dma_request_i,
    input  wire logic       fdc_interrupt_i,
    input  wire logic       terminal_count_in_i,
    // Index pins
    input  wire logic       index_normal_i,
    input  wire logic       index_alt_i,
    input  wire logic       parallel_port_drive_mode_i,
    input  wire logic       port_function_select_i,
    // Mode and gating results
    output fmps_mode_e      mode_o,
    output logic            mode_valid_o,
    output logic            dma_gate_o,
    output logic            floppy_dma_request_o,
    output logic            floppy_interrupt_out_o,
    output logic            terminal_count_o,
    output logic            status_regs_visible_o,
    output logic            index_o,
    // Density select
    output logic            density_select_out_o,
    // Shared pin: idle or motor
    output logic            idle_motor_pin_o,
    // Shared pin: channel ready (open drain) or encoding
    output logic            ready_enc_pin_o,
    output logic            ready_enc_pin_oe_o
);

    logic [1:0] strap_sync;
    logic [1:0] strap_q;
    logic [1:0] settle_q;
    logic       captured_q;

    fmps_sync #(.WIDTH(2)) u_sync (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .async_i   ({ident_strap_i, encoding_strap_i}),
        .sync_o    (strap_sync)
    );

    // Capture once the synchroniser has filled after reset
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            settle_q   <= STRAP_RESET;
            captured_q <= 1'b0;
            strap_q    <= STRAP_RESET;
        end
        else
        begin
            if (settle_q != SETTLE_LAST)
            begin
                settle_q <= settle_q + 2'h1;
            end
            if (settle_q == SETTLE_LAST && !captured_q)
            begin
                strap_q    <= strap_sync;
                captured_q <= 1'b1;
            end
        end
    end

    wire strap_ident = strap_q[1];
    wire fast_rate   = (data_rate_i == RATE_500K) || (data_rate_i == RATE_1M);

    // Mode decode
    always_comb
    begin
        unique case (strap_q)
            STRAP_FIRST:   mode_o = FMPS_MODE_FIRST;
            STRAP_SECOND:  mode_o = FMPS_MODE_SECOND;
            STRAP_THIRD:   mode_o = FMPS_MODE_THIRD;
            STRAP_ILLEGAL: mode_o = FMPS_MODE_ILLEGAL;
        endcase
    end

    wire is_third = (mode_o == FMPS_MODE_THIRD);

    assign mode_valid_o  = captured_q;
    wire dma_en_bit = digital_output_reg_i[DOUT_DMA_EN_BIT];
    assign dma_gate_o    = is_third ? 1'b1 : dma_en_bit;
    assign floppy_dma_request_o   = dma_request_i & dma_gate_o;
    assign floppy_interrupt_out_o = fdc_interrupt_i & dma_gate_o;
    assign terminal_count_o = is_third ? ~terminal_count_in_i
                            : terminal_count_in_i;
    assign status_regs_visible_o = (mode_o == FMPS_MODE_SECOND) ||
                                   is_third;

    // Index source in parallel drive mode
    wire alt_index_sel = parallel_port_drive_mode_i &&
                         !port_function_select_i;
    assign index_o = alt_index_sel ? index_alt_i : index_normal_i;

    // Density polarity follows captured identity
    assign density_select_out_o = fast_rate ? strap_ident
                                : ~strap_ident;

    wire idle_level = fdc_idle_i | fdc_power_down_i;
    wire idle_sel = power_mgmt_control_reg_i[PWR_IDLE_SEL_BIT];
    assign idle_motor_pin_o = idle_sel
                            ? idle_level
                            : drive1_motor_select_i;

    wire enc_sel = function_control_reg_i[FUNC_ENC_SEL_BIT];
    assign ready_enc_pin_o    = enc_sel ? encoding_format_i : 1'b0;
    assign ready_enc_pin_oe_o = enc_sel | epp_wait_i;

    strap_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        captured_q && $past(captured_q) |-> $stable(strap_q))
        else $error("strap changed after capture");
    mode_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        mode_valid_o |=> mode_valid_o && $stable(mode_o))
        else $error("mode changed after capture");
    early_mode_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !captured_q |-> mode_o == FMPS_MODE_SECOND && !mode_valid_o)
        else $error("mode shown before capture");
    capture_delay_a: assert property (
        @(posedge ref_clk_i)
        $fell(srst_i) |-> !captured_q [*4] ##1 captured_q)
        else $error("capture timing wrong");
    third_count_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        is_third |-> terminal_count_o != terminal_count_in_i)
        else $error("third mode count not inverted");
    third_dma_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        is_third && dma_request_i |-> floppy_dma_request_o)
        else $error("third mode dma gated");
    third_irq_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        is_third && fdc_interrupt_i |-> floppy_interrupt_out_o)
        else $error("third mode interrupt gated");
    third_show_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        is_third |-> status_regs_visible_o)
        else $error("third mode status hidden");
    first_hide_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        mode_o == FMPS_MODE_FIRST |-> !status_regs_visible_o)
        else $error("first mode status visible");
    first_gate_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        mode_o == FMPS_MODE_FIRST |-> dma_gate_o == dma_en_bit &&
        terminal_count_o == terminal_count_in_i)
        else $error("first mode gating wrong");
    second_show_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        mode_o == FMPS_MODE_SECOND |-> status_regs_visible_o &&
        dma_gate_o == dma_en_bit &&
        terminal_count_o == terminal_count_in_i)
        else $error("second mode gating wrong");
    dens_fast_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        fast_rate |-> density_select_out_o == strap_q[1])
        else $error("density polarity wrong");
    dens_slow_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !fast_rate |-> density_select_out_o != strap_q[1])
        else $error("density slow polarity wrong");
    idle_pin_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        idle_sel && (fdc_idle_i || fdc_power_down_i)
        |-> idle_motor_pin_o)
        else $error("idle pin low while idle");
    idle_low_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        idle_sel && !fdc_idle_i && !fdc_power_down_i
        |-> !idle_motor_pin_o)
        else $error("idle pin high while busy");
    motor_pin_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !idle_sel |-> idle_motor_pin_o == drive1_motor_select_i)
        else $error("motor pin wrong");
    ready_pull_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !enc_sel |-> ready_enc_pin_oe_o == epp_wait_i && !ready_enc_pin_o)
        else $error("ready pin wrong");
    enc_pin_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        enc_sel |-> ready_enc_pin_oe_o &&
        ready_enc_pin_o == encoding_format_i)
        else $error("encoding pin wrong");
    index_alt_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        alt_index_sel |-> index_o == index_alt_i)
        else $error("alternate index not routed");
    index_norm_a: assert property (
        @(posedge ref_clk_i) disable iff (srst_i)
        !alt_index_sel |-> index_o == index_normal_i)
        else $error("normal index not routed");

endmodule : fmps_top

// File: dv/fmps_far_model.sv
// Purpose: Far-side model: index pulses and ready-line pull-up
// Assumes: Counter steps on the falling edge, like the bench
// Notes:   Alternate index pulses out of phase with the normal one
module fmps_far_model
(
    // Clock
    input  wire logic ref_clk_i,
    // Shared ready pin from the device
    input  wire logic ready_enc_pin_i,
    input  wire logic ready_enc_pin_oe_i,
    // Drive and bus side
    output logic      index_normal_o,
    output logic      index_alt_o,
    output logic      ready_wire_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt_q = 3'h0;
    always_ff @(negedge ref_clk_i)
    begin
        cnt_q <= cnt_q + 3'h1;
    end
    // One pulse per track on each index line
    assign index_normal_o = (cnt_q == 3'h0);
    assign index_alt_o    = (cnt_q == 3'h4);
    // Pull-up on the open-drain line
    assign ready_wire_o = ready_enc_pin_oe_i ? ready_enc_pin_i : 1'b1;
endmodule : fmps_far_model

// File: dv/tb.sv
// Purpose: Self-checking bench for fmps_top
// Assumes: Inputs change at the falling clock edge
// Notes:   Each strap code gets its own reset
module tb
    import fmps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    mismatches++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
    int mismatches = 0;
    int comparisons = 0;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ident_strap_i, encoding_strap_i, fdc_idle_i, fdc_power_down_i;
    logic encoding_format_i, epp_wait_i, drive1_motor_select_i, ready_wire;
    logic dma_request_i, fdc_interrupt_i, terminal_count_in_i, index_alt_i;
    logic parallel_port_drive_mode_i, port_function_select_i, index_normal_i;
    logic [7:0] digital_output_reg_i, power_mgmt_control_reg_i;
    logic [7:0] function_control_reg_i;
    logic [1:0] data_rate_i;
    fmps_mode_e mode_o;
    logic mode_valid_o, dma_gate_o, floppy_dma_request_o, index_o;
    logic floppy_interrupt_out_o, terminal_count_o, status_regs_visible_o;
    logic density_select_out_o, idle_motor_pin_o;
    logic ready_enc_pin_o, ready_enc_pin_oe_o;
    fmps_mode_e exp_mode [4] = '{FMPS_MODE_SECOND, FMPS_MODE_THIRD,
        FMPS_MODE_ILLEGAL, FMPS_MODE_FIRST};

    fmps_top fmps_top_i (.ref_clk_i, .srst_i, .ident_strap_i,
        .encoding_strap_i, .digital_output_reg_i, .power_mgmt_control_reg_i,
        .function_control_reg_i, .data_rate_i, .fdc_idle_i, .fdc_power_down_i,
        .encoding_format_i, .epp_wait_i, .drive1_motor_select_i,
        .dma_request_i, .fdc_interrupt_i, .terminal_count_in_i,
        .index_normal_i,
        .index_alt_i, .parallel_port_drive_mode_i, .port_function_select_i,
        .mode_o, .mode_valid_o, .dma_gate_o, .floppy_dma_request_o,
        .floppy_interrupt_out_o, .terminal_count_o, .status_regs_visible_o,
        .index_o, .density_select_out_o, .idle_motor_pin_o,
        .ready_enc_pin_o, .ready_enc_pin_oe_o);
    fmps_far_model fmps_far_model_i (.ref_clk_i,
        .ready_enc_pin_i(ready_enc_pin_o),
        .ready_enc_pin_oe_i(ready_enc_pin_oe_o),
        .index_normal_o(index_normal_i), .index_alt_o(index_alt_i),
        .ready_wire_o(ready_wire));

    initial
    begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic strap_reset(input logic [1:0] code);
        @(negedge ref_clk_i);
        {ident_strap_i, encoding_strap_i} = code;
        srst_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        srst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        `CHK("early valid", 1'b0, mode_valid_o)
        `CHK("early mode", FMPS_MODE_SECOND, mode_o)
        repeat (4) @(negedge ref_clk_i);
    endtask : strap_reset

    initial
    begin
        logic th;
        logic sel;
        {ident_strap_i, encoding_strap_i, fdc_idle_i, fdc_power_down_i,
         encoding_format_i, epp_wait_i, drive1_motor_select_i,
         terminal_count_in_i, parallel_port_drive_mode_i,
         port_function_select_i, digital_output_reg_i, data_rate_i,
         power_mgmt_control_reg_i, function_control_reg_i} = '0;
        {dma_request_i, fdc_interrupt_i} = 2'h3;
        for (int s = 0; s < 4; s++)
        begin
            strap_reset(2'(s));
            th = (s == 1);
            `CHK("mode", exp_mode[s], mode_o)
            `CHK("valid", 1'b1, mode_valid_o)
            `CHK("visible", 1'(s < 2), status_regs_visible_o)
            for (int d = 0; d < 2; d++)
            begin
                digital_output_reg_i = d ? 8'h08 : 8'h00;
                terminal_count_in_i = d[0];
                data_rate_i = d ? (s[0] ? RATE_1M : RATE_500K) : 2'h2;
                #2;
                `CHK("gate", th | d[0], dma_gate_o)
                `CHK("irq", th | d[0], floppy_interrupt_out_o)
                `CHK("dreq", th | d[0], floppy_dma_request_o)
                `CHK("count", th ^ d[0], terminal_count_o)
                `CHK("dens", 1'(s[1] ~^ d[0]), density_select_out_o)
                @(negedge ref_clk_i);
            end
        end
        {ident_strap_i, encoding_strap_i} = 2'h0;
        repeat (8) @(negedge ref_clk_i);
        `CHK("held", FMPS_MODE_FIRST, mode_o)
        for (int k = 0; k < 8; k++)
        begin
            power_mgmt_control_reg_i = k[0] ? 8'h10 : 8'h00;
            function_control_reg_i = k[1] ? 8'h80 : 8'h00;
            fdc_idle_i = k[2];
            fdc_power_down_i = k[1] & ~k[2];
            drive1_motor_select_i = ~k[2];
            {encoding_format_i, epp_wait_i} = {2{k[0] ^ k[2]}};
            #2;
            `CHK("idle", k[0] ? k[1] | k[2] : ~k[2], idle_motor_pin_o)
            `CHK("ready", 1'(k[1] ~^ (k[0] ^ k[2])), ready_wire)
            @(negedge ref_clk_i);
        end
        for (int j = 0; j < 32; j++)
        begin
            {parallel_port_drive_mode_i, port_function_select_i} = 2'(j >> 3);
            #2;
            sel = parallel_port_drive_mode_i & ~port_function_select_i;
            `CHK("index", sel ? index_alt_i : index_normal_i, index_o)
            @(negedge ref_clk_i);
        end
        end_of_test();
    end

    initial
    begin
        #20000;
        mismatches++;
        end_of_test();
    end
endmodule : tb
